/* core/sppc_defines.svh */
// Purpose: Offsets, field positions, reset values of the port policy regs
// Assumes: Register index times four gives the APB byte address
// Notes: Definitions only
`ifndef SPPC_DEFINES_SVH
`define SPPC_DEFINES_SVH

// ==========================================================
// Register indexes (byte address = index * 4)
`define SPPC_P1_CTRL1_IDX 6'h11
`define SPPC_P1_CTRL2_IDX 6'h12
`define SPPC_P2_CTRL1_IDX 6'h21
`define SPPC_P2_CTRL2_IDX 6'h22
`define SPPC_P3_CTRL1_IDX 6'h31
`define SPPC_P3_CTRL2_IDX 6'h32

// ==========================================================
// First control register fields
`define SPPC_C1_SNIFFER 7
`define SPPC_C1_RX_SNIFF 6
`define SPPC_C1_TX_SNIFF 5
`define SPPC_C1_DBL_TAG 4
`define SPPC_C1_PRIO_CEIL 3
`define SPPC_C1_MEMB_HI 2
`define SPPC_C1_MEMB_LO 0

// ==========================================================
// Second control register fields
`define SPPC_C2_RSVD 7
`define SPPC_C2_IN_VLAN_FILT 6
`define SPPC_C2_DROP_NON_PVID 5
`define SPPC_C2_FORCE_PAUSE 4
`define SPPC_C2_BACKPRESS 3
`define SPPC_C2_TX_EN 2
`define SPPC_C2_RX_EN 1
`define SPPC_C2_LEARN_DIS 0

// ==========================================================
// Reset values and default tag layout
`define SPPC_C1_RST 8'h07
`define SPPC_C2_RST 8'h06
`define SPPC_TAG_PRIO_HI 15
`define SPPC_TAG_PRIO_LO 13
`define SPPC_TAG_CFI 12
`define SPPC_TAG_VID_HI 11
`define SPPC_TAG_VID_LO 0

`endif

/* core/sppc_pkg.sv */
// Purpose: Types shared by the port policy control files
// Assumes: Nothing
// Notes: Constants live in sppc_defines.svh
package sppc_pkg;

    // Start-up sequence for loading the pause straps
    typedef enum logic [1:0] {
        BOOT_SYNC1,
        BOOT_SYNC2,
        BOOT_LOAD,
        BOOT_RUN
    } sppc_boot_t;

endpackage

/* core/sppc_port_regs.sv */
// Purpose: The two control registers of one switch port
// Assumes: Writes never coincide with the strap load
// Notes: Strap capture happens once, after reset release
`timescale 1ns/1ps
`include "sppc_defines.svh"

module sppc_port_regs #(
    parameter bit HAS_STRAP = 1'b1
) (
    input wire logic clk_i, // Switch clock
    input wire logic arst_n_i, // Async reset, low
    input wire logic wr1_i, // Write first register
    input wire logic wr2_i, // Write second register
    input wire logic [7:0] wdata_i, // Write data
    input wire logic strap_load_i, // Strap capture strobe
    input wire logic strap_i, // Synchronised strap level
    output logic [7:0] ctrl1_o, // First register
    output logic [7:0] ctrl2_o // Second register
);

    logic [7:0] ctrl1_reg;
    logic [7:0] ctrl2_reg;
    logic [7:0] ctrl1_next;
    logic [7:0] ctrl2_next;
    logic [7:0] strap_val_w;

    // Only the pause bit follows the strap; others keep their value
    assign strap_val_w = HAS_STRAP ?
        (ctrl2_reg & ~(8'h01 << `SPPC_C2_FORCE_PAUSE)) |
        ({7'h00, strap_i} << `SPPC_C2_FORCE_PAUSE) : ctrl2_reg;

    assign ctrl1_next = wr1_i ? wdata_i : ctrl1_reg;
    assign ctrl2_next = wr2_i ? wdata_i :
        (strap_load_i ? strap_val_w : ctrl2_reg);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl1_reg <= `SPPC_C1_RST;
            ctrl2_reg <= `SPPC_C2_RST;
        end else begin
            ctrl1_reg <= ctrl1_next;
            ctrl2_reg <= ctrl2_next;
        end
    end

    assign ctrl1_o = ctrl1_reg;
    assign ctrl2_o = ctrl2_reg;

endmodule

/* core/sppc_top.sv */
// Purpose: Per-port policy control of a three-port switch, APB regs
// Assumes: Descriptor inputs come from logic on clk_i
// Notes: One packet decision per cycle, answered one cycle later
//
// How it works
// - First control register of ports 1..3 at indexes 0x11, 0x21, 0x31.
// - Second control register of ports 1..3 at indexes 0x12, 0x22, 0x32.
// - Bit 7 makes the port a mirror destination for monitored packets.
// - Bit 6 marks all packets received on the port as monitored.
// - Bit 5 marks all packets sent on the port as monitored.
// - Bit 4 adds ingress default tag to every packet, tagged or not.
// - Bit 3 caps packet priority at the default tag priority.
// - Bits 2..0 are egress membership, port 3..1, reset all ones.
// - A port's membership mask limits its forwarded packets, not its mirror copies.
// - Second reg bit 6 drops packets whose VLAN lacks ingress port.
// - Second reg bit 5 drops packets whose VID differs from default.
// - Second reg bit 4 forces full-duplex pause on ports 1, 2, else negotiated.
// - Ports 1, 2 pause bit loads strap after reset release; port 3 ignores it.
// - Second reg bit 3 enables half-duplex back pressure, reset zero.
// - Second reg bit 2 permits transmission, resets to one.
// - Second reg bit 1 permits reception, resets to one.
// - Second reg bit 0 stops address learning, resets to zero.
// - Default tag: priority 15..13, CFI 12, VID 11..0.
// - Default VID applies to untagged and null-VID packets.
`timescale 1ns/1ps
`include "sppc_defines.svh"

module sppc_top #(
    parameter int NPORTS = 3
) (
    input wire logic clk_i, // Switch clock, 100 MHz
    input wire logic arst_n_i, // Async reset, low
    // APB slave
    input wire logic psel_i, // Select
    input wire logic penable_i, // Access phase
    input wire logic pwrite_i, // Write
    input wire logic [7:0] paddr_i, // Byte address
    input wire logic [31:0] pwdata_i, // Write data
    input wire logic [3:0] pstrb_i, // Byte strobes
    output logic [31:0] prdata_o, // Read data
    output logic pready_o, // Ready
    output logic pslverr_o, // Unmapped access
    // Straps, raw pins
    input wire logic first_port_forced_pause_strap_i, // Port 1 strap
    input wire logic second_port_forced_pause_strap_i, // Port 2 strap
    // Port levels
    input wire logic [NPORTS-1:0] an_pause_i, // Negotiated pause
    output logic [NPORTS-1:0] port_pause_en_o, // Full-duplex pause
    output logic [NPORTS-1:0] port_backpress_o, // Half-duplex BP
    output logic [NPORTS-1:0] port_tx_en_o, // Transmit allowed
    output logic [NPORTS-1:0] port_rx_en_o, // Receive allowed
    // Packet descriptor
    input wire logic pkt_valid_i, // Descriptor valid
    input wire logic [1:0] pkt_src_i, // Ingress port 1..3
    input wire logic pkt_tagged_i, // Arrived tagged
    input wire logic [11:0] pkt_vid_i, // Packet VID
    input wire logic [2:0] pkt_prio_i, // Packet priority
    input wire logic [NPORTS-1:0] pkt_vlan_memb_i, // VLAN table members
    input wire logic [NPORTS-1:0] pkt_dest_i, // Lookup destinations
    input wire logic [15:0] dflt_tag1_i, // Port 1 default tag
    input wire logic [15:0] dflt_tag2_i, // Port 2 default tag
    input wire logic [15:0] dflt_tag3_i, // Port 3 default tag
    // Decision
    output logic res_valid_o, // Decision valid
    output logic [NPORTS-1:0] res_fwd_o, // Normal egress ports
    output logic [NPORTS-1:0] res_mirror_o, // Extra mirror copies
    output logic res_drop_o, // Packet discarded
    output logic res_add_tag_o, // Insert default tag
    output logic [2:0] res_prio_o, // Resulting priority
    output logic [11:0] res_vid_o, // Effective VID
    output logic res_learn_o // Learn source address
);

    // ==========================================================
    // Helpers
    function automatic logic [2:0] tag_prio(input logic [15:0] t);
        tag_prio = t[`SPPC_TAG_PRIO_HI:`SPPC_TAG_PRIO_LO];
    endfunction

    function automatic logic [11:0] tag_vid(input logic [15:0] t);
        tag_vid = t[`SPPC_TAG_VID_HI:`SPPC_TAG_VID_LO];
    endfunction

    function automatic logic idx_hit(input logic [5:0] a,
                                     input logic [5:0] b);
        idx_hit = (a == b);
    endfunction

    // ==========================================================
    // Strap synchroniser and start-up sequence
    logic [1:0] strap_s1_reg;
    logic [1:0] strap_s2_reg;
    sppc_pkg::sppc_boot_t boot_reg;
    sppc_pkg::sppc_boot_t boot_next;
    logic strap_load_w;
    logic run_w;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strap_s1_reg <= 2'h0;
            strap_s2_reg <= 2'h0;
        end else begin
            strap_s1_reg <= {second_port_forced_pause_strap_i,
                             first_port_forced_pause_strap_i};
            strap_s2_reg <= strap_s1_reg;
        end
    end

    // Wait until the synchroniser holds the post-reset level
    always_comb begin
        case (boot_reg)
            sppc_pkg::BOOT_SYNC1: boot_next = sppc_pkg::BOOT_SYNC2;
            sppc_pkg::BOOT_SYNC2: boot_next = sppc_pkg::BOOT_LOAD;
            sppc_pkg::BOOT_LOAD: boot_next = sppc_pkg::BOOT_RUN;
            sppc_pkg::BOOT_RUN: boot_next = sppc_pkg::BOOT_RUN;
            default: boot_next = sppc_pkg::BOOT_SYNC1;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            boot_reg <= sppc_pkg::BOOT_SYNC1;
        end else begin
            boot_reg <= boot_next;
        end
    end

    assign strap_load_w = (boot_reg == sppc_pkg::BOOT_LOAD);
    assign run_w = (boot_reg == sppc_pkg::BOOT_RUN);

    // ==========================================================
    // APB decode
    logic [5:0] idx_w;
    logic aligned_w;
    logic [NPORTS-1:0] hit1_w;
    logic [NPORTS-1:0] hit2_w;
    logic mapped_w;
    logic [7:0] rd_byte_w;
    logic wr_done_w;
    logic apb_access_w;
    logic ready_reg;
    logic ready_next;
    logic [31:0] rdata_reg;
    logic slverr_reg;

    assign idx_w = paddr_i[7:2];
    assign aligned_w = (paddr_i[1:0] == 2'h0);
    assign hit1_w[0] = aligned_w & idx_hit(idx_w, `SPPC_P1_CTRL1_IDX);
    assign hit1_w[1] = aligned_w & idx_hit(idx_w, `SPPC_P2_CTRL1_IDX);
    assign hit1_w[2] = aligned_w & idx_hit(idx_w, `SPPC_P3_CTRL1_IDX);
    assign hit2_w[0] = aligned_w & idx_hit(idx_w, `SPPC_P1_CTRL2_IDX);
    assign hit2_w[1] = aligned_w & idx_hit(idx_w, `SPPC_P2_CTRL2_IDX);
    assign hit2_w[2] = aligned_w & idx_hit(idx_w, `SPPC_P3_CTRL2_IDX);
    assign mapped_w = |{hit1_w, hit2_w};

    // Held off until straps are in, so no write races the load
    assign ready_next = psel_i & ~ready_reg & run_w;
    // Completion edge: the only edge at which a write lands
    assign apb_access_w = psel_i & penable_i & ready_reg;
    assign wr_done_w = apb_access_w & pwrite_i & pstrb_i[0];

    logic [7:0] ctrl1_w [NPORTS];
    logic [7:0] ctrl2_w [NPORTS];

    always_comb begin
        rd_byte_w = 8'h00;
        for (int p = 0; p < NPORTS; p++) begin
            rd_byte_w = rd_byte_w | ({8{hit1_w[p]}} & ctrl1_w[p])
                | ({8{hit2_w[p]}} & ctrl2_w[p]);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ready_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            slverr_reg <= 1'b0;
        end else begin
            ready_reg <= ready_next;
            if (ready_next) begin
                rdata_reg <= {24'h00_0000, rd_byte_w};
                slverr_reg <= ~mapped_w;
            end
        end
    end

    assign prdata_o = rdata_reg;
    assign pready_o = ready_reg;
    assign pslverr_o = slverr_reg;

    // ==========================================================
    // Port register pairs
    logic [NPORTS-1:0] strap_w;

    assign strap_w = {1'b0, strap_s2_reg};

    for (genvar g = 0; g < NPORTS; g++) begin : g_port
        sppc_port_regs #(
            .HAS_STRAP(g < 2)
        ) u_regs (
            .clk_i(clk_i),
            .arst_n_i(arst_n_i),
            .wr1_i(wr_done_w & hit1_w[g]),
            .wr2_i(wr_done_w & hit2_w[g]),
            .wdata_i(pwdata_i[7:0]),
            .strap_load_i(strap_load_w),
            .strap_i(strap_w[g]),
            .ctrl1_o(ctrl1_w[g]),
            .ctrl2_o(ctrl2_w[g])
        );
    end

    // ==========================================================
    // Field views
    logic [NPORTS-1:0] sniffer_w;
    logic [NPORTS-1:0] rx_sniff_w;
    logic [NPORTS-1:0] tx_sniff_w;
    logic [NPORTS-1:0] dbl_tag_w;
    logic [NPORTS-1:0] ceil_w;
    logic [NPORTS-1:0] vfilt_w;
    logic [NPORTS-1:0] pvid_only_w;
    logic [NPORTS-1:0] force_w;
    logic [NPORTS-1:0] bp_w;
    logic [NPORTS-1:0] txen_w;
    logic [NPORTS-1:0] rxen_w;
    logic [NPORTS-1:0] nolearn_w;
    logic [NPORTS-1:0] memb_w [NPORTS];

    always_comb begin
        for (int p = 0; p < NPORTS; p++) begin
            sniffer_w[p] = ctrl1_w[p][`SPPC_C1_SNIFFER];
            rx_sniff_w[p] = ctrl1_w[p][`SPPC_C1_RX_SNIFF];
            tx_sniff_w[p] = ctrl1_w[p][`SPPC_C1_TX_SNIFF];
            dbl_tag_w[p] = ctrl1_w[p][`SPPC_C1_DBL_TAG];
            ceil_w[p] = ctrl1_w[p][`SPPC_C1_PRIO_CEIL];
            memb_w[p] = ctrl1_w[p][`SPPC_C1_MEMB_HI:`SPPC_C1_MEMB_LO];
            vfilt_w[p] = ctrl2_w[p][`SPPC_C2_IN_VLAN_FILT];
            pvid_only_w[p] = ctrl2_w[p][`SPPC_C2_DROP_NON_PVID];
            force_w[p] = ctrl2_w[p][`SPPC_C2_FORCE_PAUSE];
            bp_w[p] = ctrl2_w[p][`SPPC_C2_BACKPRESS];
            txen_w[p] = ctrl2_w[p][`SPPC_C2_TX_EN];
            rxen_w[p] = ctrl2_w[p][`SPPC_C2_RX_EN];
            nolearn_w[p] = ctrl2_w[p][`SPPC_C2_LEARN_DIS];
        end
    end

    // ==========================================================
    // Port level outputs
    logic [NPORTS-1:0] pause_next;

    // Port 3 has its pause set elsewhere, so its bit is ignored
    assign pause_next = an_pause_i | (force_w & 3'h3);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_pause_en_o <= 3'h0;
            port_backpress_o <= 3'h0;
            port_tx_en_o <= 3'h0;
            port_rx_en_o <= 3'h0;
        end else begin
            port_pause_en_o <= pause_next;
            port_backpress_o <= bp_w;
            port_tx_en_o <= txen_w;
            port_rx_en_o <= rxen_w;
        end
    end

    // ==========================================================
    // Packet decision
    logic src_ok_w;
    logic [1:0] s_w;
    logic [NPORTS-1:0] src_bit_w;
    logic [15:0] dtag_w;
    logic [11:0] dvid_w;
    logic [11:0] evid_w;
    logic [2:0] dprio_w;
    logic drop_w;
    logic [NPORTS-1:0] fwd_w;
    logic monitored_w;
    logic [NPORTS-1:0] mirror_w;
    logic [2:0] prio_w;
    logic add_tag_w;
    logic learn_w;

    assign src_ok_w = (pkt_src_i != 2'h0);
    assign s_w = src_ok_w ? pkt_src_i - 2'h1 : 2'h0;
    assign src_bit_w = 3'h1 << s_w;
    assign dtag_w = (s_w == 2'h0) ? dflt_tag1_i :
        (s_w == 2'h1) ? dflt_tag2_i : dflt_tag3_i;
    assign dvid_w = tag_vid(dtag_w);
    assign dprio_w = tag_prio(dtag_w);
    // Untagged or null-VID frames adopt the port VID
    assign evid_w = (!pkt_tagged_i || pkt_vid_i == 12'h000) ?
        dvid_w : pkt_vid_i;

    assign drop_w = ~src_ok_w | ~rxen_w[s_w]
        | (vfilt_w[s_w] & ~pkt_vlan_memb_i[s_w])
        | (pvid_only_w[s_w] & (evid_w != dvid_w));

    // Egress limited by membership and transmit enable
    assign fwd_w = drop_w ? 3'h0 :
        pkt_dest_i & memb_w[s_w] & txen_w & ~src_bit_w;

    assign monitored_w = rx_sniff_w[s_w]
        | (|(tx_sniff_w & fwd_w));
    // Copies only to sniffers not already receiving it
    assign mirror_w = (monitored_w && !drop_w) ?
        sniffer_w & txen_w & ~fwd_w & ~src_bit_w : 3'h0;

    assign prio_w = (ceil_w[s_w] && pkt_prio_i > dprio_w) ?
        dprio_w : pkt_prio_i;

    assign add_tag_w = dbl_tag_w[s_w];
    // Learning ignores VLAN drops; only receive gating, the learn-disable bit or a zero source stops it
    assign learn_w = pkt_valid_i & src_ok_w & rxen_w[s_w]
        & ~nolearn_w[s_w];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            res_valid_o <= 1'b0;
            res_fwd_o <= 3'h0;
            res_mirror_o <= 3'h0;
            res_drop_o <= 1'b0;
            res_add_tag_o <= 1'b0;
            res_prio_o <= 3'h0;
            res_vid_o <= 12'h000;
            res_learn_o <= 1'b0;
        end else begin
            res_valid_o <= pkt_valid_i;
            res_fwd_o <= fwd_w;
            res_mirror_o <= mirror_w;
            res_drop_o <= drop_w;
            res_add_tag_o <= add_tag_w;
            res_prio_o <= prio_w;
            res_vid_o <= evid_w;
            res_learn_o <= learn_w;
        end
    end

endmodule

/* dv/sppc_sva.sv */
// Purpose: Checker for the port policy block, sees top ports only
// Assumes: One clock domain, reset low asynchronous
// Notes: Bound to every sppc_top instance
`timescale 1ns/1ps
module sppc_sva #(
    parameter int NPORTS = 3
) (
    input wire logic clk_i, // Clock
    input wire logic arst_n_i, // Reset, low
    input wire logic psel_i, // Select
    input wire logic penable_i, // Access
    input wire logic [7:0] paddr_i, // Address
    input wire logic [31:0] prdata_o, // Read data
    input wire logic pready_o, // Ready
    input wire logic pslverr_o, // Error
    input wire logic [NPORTS-1:0] an_pause_i, // Negotiated
    input wire logic [NPORTS-1:0] port_pause_en_o, // Pause out
    input wire logic pkt_valid_i, // Descriptor
    input wire logic [1:0] pkt_src_i, // Source
    input wire logic pkt_tagged_i, // Tagged
    input wire logic [11:0] pkt_vid_i, // VID
    input wire logic [2:0] pkt_prio_i, // Priority
    input wire logic [NPORTS-1:0] pkt_dest_i, // Lookup
    input wire logic res_valid_o, // Result
    input wire logic [NPORTS-1:0] res_fwd_o, // Egress
    input wire logic [NPORTS-1:0] res_mirror_o, // Mirror
    input wire logic res_drop_o, // Drop
    input wire logic [2:0] res_prio_o, // Priority
    input wire logic [11:0] res_vid_o, // VID
    input wire logic res_learn_o // Learn
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    // ==========================================================
    // Register bus
    chk_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held past one cycle");
    chk_ready_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access phase");
    chk_misalign_err: assert property (pready_o && paddr_i[1:0] != 2'h0
        |-> pslverr_o && prdata_o == 32'h0) else $error("misaligned accepted");
    // ==========================================================
    // Packet decision
    chk_result_latency: assert property (pkt_valid_i |=> res_valid_o)
        else $error("result not one cycle later");
    chk_no_spurious: assert property (!pkt_valid_i |=> !res_valid_o &&
        !res_learn_o) else $error("result without descriptor");
    chk_src_zero_drop: assert property (pkt_valid_i && pkt_src_i == 2'h0
        |=> res_drop_o && res_fwd_o == 3'h0) else $error("bad source kept");
    chk_fwd_in_dest: assert property (pkt_valid_i |=>
        (res_fwd_o & ~$past(pkt_dest_i)) == 3'h0) else $error("fwd not in dest");
    chk_mirror_extra: assert property (res_valid_o |->
        (res_mirror_o & res_fwd_o) == 3'h0) else $error("mirror overlaps fwd");
    chk_prio_capped: assert property (pkt_valid_i |=>
        res_prio_o <= $past(pkt_prio_i)) else $error("priority raised");
    chk_tagged_vid: assert property (pkt_valid_i && pkt_tagged_i &&
        pkt_vid_i != 12'h0 |=> res_vid_o == $past(pkt_vid_i))
        else $error("tagged VID replaced");
    // ==========================================================
    // Pause
    chk_pause_follow: assert property (an_pause_i != 3'h0 |=>
        (port_pause_en_o & $past(an_pause_i)) == $past(an_pause_i))
        else $error("negotiated pause lost");
    chk_port3_pause: assert property (1'b1 |=>
        port_pause_en_o[2] == $past(an_pause_i[2])) else $error("port 3 forced");
    cover property (res_valid_o && res_mirror_o != 3'h0);
    cover property (res_valid_o && res_drop_o);
    cover property (pready_o && pslverr_o);
endmodule

bind sppc_top sppc_sva #(.NPORTS(NPORTS)) sppc_sva_i (.clk_i, .arst_n_i,
    .psel_i, .penable_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
    .an_pause_i, .port_pause_en_o, .pkt_valid_i, .pkt_src_i, .pkt_tagged_i,
    .pkt_vid_i, .pkt_prio_i, .pkt_dest_i, .res_valid_o, .res_fwd_o,
    .res_mirror_o, .res_drop_o, .res_prio_o, .res_vid_o, .res_learn_o);

/* dv/tb.sv */
// Purpose: Directed bench for the port policy block over APB
// Assumes: Port 1 strap high, port 2 strap low, fixed default tags
// Notes: Expected decisions worked out by hand per case
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [3:0] pstrb_i = 4'hF;
    logic first_port_forced_pause_strap_i = 1'b1;
    logic second_port_forced_pause_strap_i = 1'b0;
    logic [2:0] an_pause_i = 3'h0;
    logic pkt_valid_i = 1'b0, pkt_tagged_i = 1'b0;
    logic [1:0] pkt_src_i = 2'h0;
    logic [11:0] pkt_vid_i = 12'h0;
    logic [2:0] pkt_prio_i = 3'h0, pkt_vlan_memb_i = 3'h0, pkt_dest_i = 3'h0;
    logic [15:0] dflt_tag1_i = 16'h4005, dflt_tag2_i = 16'h6007;
    logic [15:0] dflt_tag3_i = 16'h2009;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, res_valid_o, res_drop_o;
    logic res_add_tag_o, res_learn_o;
    logic [2:0] port_pause_en_o, port_backpress_o, port_tx_en_o;
    logic [2:0] port_rx_en_o, res_fwd_o, res_mirror_o, res_prio_o;
    logic [11:0] res_vid_o;
    int n_fail = 0;
    int compares = 0;
    logic [7:0] ad [6] = '{8'h44, 8'h48, 8'h84, 8'h88, 8'hC4, 8'hC8};
    logic [7:0] rv [6] = '{8'h07, 8'h16, 8'h07, 8'h06, 8'h07, 8'h06};
    logic [7:0] cv [6] = '{8'h0F, 8'h16, 8'h87, 8'h47, 8'h75, 8'h26};

    sppc_top #(.NPORTS(3)) sppc_top_i (.clk_i, .arst_n_i, .psel_i,
        .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o,
        .pready_o, .pslverr_o, .first_port_forced_pause_strap_i,
        .second_port_forced_pause_strap_i, .an_pause_i, .port_pause_en_o,
        .port_backpress_o, .port_tx_en_o, .port_rx_en_o, .pkt_valid_i,
        .pkt_src_i, .pkt_tagged_i, .pkt_vid_i, .pkt_prio_i, .pkt_vlan_memb_i,
        .pkt_dest_i, .dflt_tag1_i, .dflt_tag2_i, .dflt_tag3_i, .res_valid_o,
        .res_fwd_o, .res_mirror_o, .res_drop_o, .res_add_tag_o, .res_prio_o,
        .res_vid_o, .res_learn_o);

    initial forever #5 clk_i = ~clk_i;

    // ==========================================================
    // Tasks
    task chk(input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask

    task final_report;
        if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Waits on ready; only the watchdog ends a hung access
    task apb(input logic [7:0] a, input logic w, input logic [7:0] d,
             input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h0, d};
        pstrb_i <= s;
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1) begin
            @(posedge clk_i);
        end
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 8'h00, 4'hF, r, e);
        chk(r, {24'h0, x});
        chk({31'h0, e}, {31'h0, xe});
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, d, s, r, e);
        chk({31'h0, e}, 32'h0);
    endtask

    task ports(input logic [11:0] x);
        repeat (2) @(posedge clk_i);
        #1;
        chk({20'h0, port_pause_en_o, port_backpress_o, port_tx_en_o,
             port_rx_en_o}, {20'h0, x});
    endtask

    // Flags are valid, drop, add tag, learn
    task pk(input logic [1:0] s, input logic t, input logic [11:0] v,
            input logic [2:0] p, m, d, input logic [24:0] e);
        @(posedge clk_i);
        pkt_valid_i <= 1'b1;
        pkt_src_i <= s;
        pkt_tagged_i <= t;
        pkt_vid_i <= v;
        pkt_prio_i <= p;
        pkt_vlan_memb_i <= m;
        pkt_dest_i <= d;
        @(posedge clk_i);
        pkt_valid_i <= 1'b0;
        #1;
        chk({7'h0, res_valid_o, res_drop_o, res_add_tag_o, res_learn_o,
             res_fwd_o, res_mirror_o, res_prio_o, res_vid_o}, {7'h0, e});
    endtask

    // ==========================================================
    // Sequence
    initial begin
        repeat (12) @(posedge clk_i);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 6; i++) rd(ad[i], rv[i], 1'b0);
        ports({3'h1, 3'h0, 3'h7, 3'h7});
        rd(8'h40, 8'h00, 1'b1);
        rd(8'h46, 8'h00, 1'b1);
        pk(1, 0, 12'h0, 5, 0, 6, {4'h9, 3'h6, 3'h0, 3'h5, 12'h005});
        for (int i = 0; i < 6; i++) wr(ad[i], cv[i], 4'hF);
        wr(8'h44, 8'hFF, 4'h0);
        for (int i = 0; i < 6; i++) rd(ad[i], cv[i], 1'b0);
        pk(1, 1, 12'h123, 6, 0, 5, {4'h9, 3'h4, 3'h2, 3'h2, 12'h123});
        pk(1, 1, 12'h123, 1, 0, 2, {4'h9, 3'h2, 3'h0, 3'h1, 12'h123});
        pk(3, 0, 12'h0, 4, 0, 3, {4'hB, 3'h1, 3'h2, 3'h4, 12'h009});
        pk(3, 1, 12'h8, 4, 0, 3, {4'hF, 3'h0, 3'h0, 3'h4, 12'h008});
        pk(3, 1, 12'h9, 4, 0, 3, {4'hB, 3'h1, 3'h2, 3'h4, 12'h009});
        pk(2, 1, 12'h10, 3, 5, 5, {4'hC, 3'h0, 3'h0, 3'h3, 12'h010});
        pk(2, 1, 12'h10, 3, 2, 5, {4'h8, 3'h5, 3'h0, 3'h3, 12'h010});
        @(posedge clk_i);
        pkt_valid_i <= 1'b1;
        pkt_src_i <= 2'h0;
        @(posedge clk_i);
        pkt_valid_i <= 1'b0;
        wr(8'h48, 8'h1C, 4'hF);
        wr(8'hC8, 8'h32, 4'hF);
        ports({3'h1, 3'h1, 3'h3, 3'h6});
        @(posedge clk_i);
        an_pause_i <= 3'h6;
        ports({3'h7, 3'h1, 3'h3, 3'h6});
        pk(1, 1, 12'h123, 6, 0, 5, {4'hC, 3'h0, 3'h0, 3'h2, 12'h123});
        pk(2, 1, 12'h10, 3, 2, 5, {4'h8, 3'h1, 3'h0, 3'h3, 12'h010});
        final_report;
    end

    // Whole run is about 110 cycles
    initial begin
        #100000;
        n_fail++;
        final_report;
    end
endmodule
